// >>> include/ttcf_defs.vh
`ifndef TTCF_DEFS_VH
`define TTCF_DEFS_VH

// ==========================================================
// Register addresses on the special-function port
`define TTCF_ADDR_CTRL      8'hc8
`define TTCF_ADDR_RLD_LO    8'hca
`define TTCF_ADDR_RLD_HI    8'hcb
`define TTCF_ADDR_CNT_LO    8'hcc
`define TTCF_ADDR_CNT_HI    8'hcd

// ==========================================================
// Control register bit positions
`define TTCF_BIT_HI_FLAG    7
`define TTCF_BIT_LO_FLAG    6
`define TTCF_BIT_LO_IRQ_EN  5
`define TTCF_BIT_CAP_EN     4
`define TTCF_BIT_SPLIT      3
`define TTCF_BIT_RUN        2
`define TTCF_BIT_XCLK       0

// ==========================================================
// Reset values and byte constants
`define TTCF_RST_BYTE       8'h00
`define TTCF_RST_BIT        1'b0
`define TTCF_BYTE_MAX       8'hff
`define TTCF_WORD_MAX       16'hffff

// ==========================================================
// Clock dividers: core clock by 12, external oscillator by 8
`define TTCF_PRE_LAST       4'hb
`define TTCF_PRE_ZERO       4'h0
`define TTCF_PRE_STEP       4'h1
`define TTCF_EXT_LAST       3'h7
`define TTCF_EXT_ZERO       3'h0
`define TTCF_EXT_STEP       3'h1

`endif

// >>> rtl/ttcf_ext_clock.v
`timescale 1ns/1ps
`default_nettype none
`include "ttcf_defs.vh"

// Brings the external oscillator into the core clock domain, divides it
// by 8 and pulses once per falling edge of the divided clock.
module ttcf_ext_clock
(
	// Clock and reset
	input  wire       clk_i,
	input  wire       nrst_i,
	// Oscillator pin
	input  wire       ext_osc_i,
	// Divided clock event
	output wire       ext_tick_o
);

	reg       sync1_ff;
	reg       sync2_ff;
	reg       last_ff;
	reg [2:0] div_ff;
	reg       tick_ff;
	wire      osc_rise;

	// ==========================================================
	// Synchroniser; only the second stage is looked at
	always @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			sync1_ff <= `TTCF_RST_BIT;
			sync2_ff <= `TTCF_RST_BIT;
			last_ff  <= `TTCF_RST_BIT;
		end
		else
		begin
			sync1_ff <= ext_osc_i;
			sync2_ff <= sync1_ff;
			last_ff  <= sync2_ff;
		end
	end

	assign osc_rise = sync2_ff & ~last_ff;

	// ==========================================================
	// Divide by 8; the divided clock falls as the count wraps 7 to 0.
	// Oscillator must stay below half the core clock to be seen.
	always @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			div_ff  <= `TTCF_EXT_ZERO;
			tick_ff <= `TTCF_RST_BIT;
		end
		else
		begin
			if (osc_rise)
				div_ff <= div_ff + `TTCF_EXT_STEP;
			tick_ff <= osc_rise & (div_ff == `TTCF_EXT_LAST);
		end
	end

	assign ext_tick_o = tick_ff;

endmodule // ttcf_ext_clock
`default_nettype wire

// >>> rtl/ttcf_timer.v
`timescale 1ns/1ps
`default_nettype none
`include "ttcf_defs.vh"

module ttcf_timer
(
	// Clock and reset
	input  wire       clk_i,
	input  wire       nrst_i,
	// Special-function register port
	input  wire [7:0] sfr_addr_i,
	input  wire       sfr_wr_i,
	input  wire [7:0] sfr_wdata_i,
	output wire [7:0] sfr_rdata_o,
	// Shared settings held elsewhere
	input  wire       high_byte_clock_select_i,
	input  wire       low_byte_clock_select_i,
	input  wire       timer_irq_enable_i,
	// External oscillator pin
	input  wire       ext_osc_i,
	// Interrupt request
	output wire       irq_o
);

	// Control register fields
	reg        high_byte_overflow_flag_ff;
	reg        low_byte_overflow_flag_ff;
	reg        low_byte_irq_enable_ff;
	reg        capture_mode_enable_ff;
	reg        split_mode_select_ff;
	reg        run_control_ff;
	reg        external_clock_select_ff;
	// Count and reload
	reg  [7:0] count_low_byte_ff;
	reg  [7:0] count_high_byte_ff;
	reg  [7:0] reload_low_byte_ff;
	reg  [7:0] reload_high_byte_ff;
	reg  [7:0] nxt_count_low;
	reg  [7:0] nxt_count_high;
	reg  [7:0] nxt_reload_low;
	reg  [7:0] nxt_reload_high;
	// Prescaler and outputs
	reg  [3:0] pre_ff;
	reg        pre_tick_ff;
	reg  [7:0] rdata_ff;
	reg  [7:0] nxt_rdata;
	reg        irq_ff;
	// Events
	wire       ext_tick;
	wire       div_tick;
	wire       tick_low;
	wire       tick_high;
	wire       step_low;
	wire       step_high;
	wire       wrap_low;
	wire       wrap_high;
	wire       wrap_word;
	wire       set_high_flag;
	wire       wr_ctrl;

	// ==========================================================
	// External oscillator path
	ttcf_ext_clock u_ext_clock
	(
		.clk_i      (clk_i),
		.nrst_i     (nrst_i),
		.ext_osc_i  (ext_osc_i),
		.ext_tick_o (ext_tick)
	);

	// ==========================================================
	// Core clock divided by 12
	// divide by twelve
	always @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			pre_ff      <= `TTCF_PRE_ZERO;
			pre_tick_ff <= `TTCF_RST_BIT;
		end
		else
		begin
			pre_ff      <= (pre_ff == `TTCF_PRE_LAST) ? `TTCF_PRE_ZERO : pre_ff + `TTCF_PRE_STEP;
			pre_tick_ff <= (pre_ff == `TTCF_PRE_LAST);
		end
	end

	// ==========================================================
	// Clock source per byte. In capture mode the oscillator is what is
	// measured, so it cannot also clock the count.
	// external or prescaled source
	assign div_tick  = (external_clock_select_ff & ~capture_mode_enable_ff) ? ext_tick : pre_tick_ff;
	assign tick_low  = low_byte_clock_select_i  | div_tick;
	assign tick_high = high_byte_clock_select_i | div_tick;

	// ==========================================================
	// Step enables; 16-bit mode steps on the low byte's clock
	// mode select
	assign step_low  = split_mode_select_ff ? tick_low : (tick_low & run_control_ff);
	assign step_high = split_mode_select_ff ? (tick_high & run_control_ff) : 1'b0;
	assign wrap_low  = step_low & (count_low_byte_ff == `TTCF_BYTE_MAX);
	assign wrap_word = ~split_mode_select_ff & step_low &
		({count_high_byte_ff, count_low_byte_ff} == `TTCF_WORD_MAX);
	assign wrap_high = step_high & (count_high_byte_ff == `TTCF_BYTE_MAX);

	assign set_high_flag = wrap_high | wrap_word | (capture_mode_enable_ff & ext_tick);
	assign wr_ctrl       = sfr_wr_i & (sfr_addr_i == `TTCF_ADDR_CTRL);

	// ==========================================================
	// Next count and reload values; a software write to a byte wins
	// over the hardware update of that byte in the same cycle.
	always @*
	begin
		nxt_count_low   = count_low_byte_ff;
		nxt_count_high  = count_high_byte_ff;
		nxt_reload_low  = reload_low_byte_ff;
		nxt_reload_high = reload_high_byte_ff;
		if (split_mode_select_ff)
		begin
			if (wrap_low)
				nxt_count_low = reload_low_byte_ff;
			else if (step_low)
				nxt_count_low = count_low_byte_ff + 8'h01;
			if (wrap_high)
				nxt_count_high = reload_high_byte_ff;
			else if (step_high)
				nxt_count_high = count_high_byte_ff + 8'h01;
		end
		else
		begin
			if (wrap_word)
				{nxt_count_high, nxt_count_low} = {reload_high_byte_ff, reload_low_byte_ff};
			else if (step_low)
				{nxt_count_high, nxt_count_low} = {count_high_byte_ff, count_low_byte_ff} + 16'h0001;
		end
		if (capture_mode_enable_ff & ext_tick)
		begin
			nxt_reload_low  = count_low_byte_ff;
			nxt_reload_high = count_high_byte_ff;
		end
		if (sfr_wr_i)
		begin
			case (sfr_addr_i)
				`TTCF_ADDR_RLD_LO: nxt_reload_low  = sfr_wdata_i;
				`TTCF_ADDR_RLD_HI: nxt_reload_high = sfr_wdata_i;
				`TTCF_ADDR_CNT_LO: nxt_count_low   = sfr_wdata_i;
				`TTCF_ADDR_CNT_HI: nxt_count_high  = sfr_wdata_i;
				default:           nxt_count_low   = nxt_count_low;
			endcase
		end
	end

	// ==========================================================
	// Count and reload registers
	always @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			count_low_byte_ff   <= `TTCF_RST_BYTE;
			count_high_byte_ff  <= `TTCF_RST_BYTE;
			reload_low_byte_ff  <= `TTCF_RST_BYTE;
			reload_high_byte_ff <= `TTCF_RST_BYTE;
		end
		else
		begin
			count_low_byte_ff   <= nxt_count_low;
			count_high_byte_ff  <= nxt_count_high;
			reload_low_byte_ff  <= nxt_reload_low;
			reload_high_byte_ff <= nxt_reload_high;
		end
	end

	// ==========================================================
	// Control register
	// all bits reset to zero
	always @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			high_byte_overflow_flag_ff <= `TTCF_RST_BIT;
			low_byte_overflow_flag_ff  <= `TTCF_RST_BIT;
			low_byte_irq_enable_ff     <= `TTCF_RST_BIT;
			capture_mode_enable_ff     <= `TTCF_RST_BIT;
			split_mode_select_ff       <= `TTCF_RST_BIT;
			run_control_ff             <= `TTCF_RST_BIT;
			external_clock_select_ff   <= `TTCF_RST_BIT;
		end
		else
		begin
			high_byte_overflow_flag_ff <= set_high_flag |
				(wr_ctrl ? sfr_wdata_i[`TTCF_BIT_HI_FLAG] : high_byte_overflow_flag_ff);
			low_byte_overflow_flag_ff  <= wrap_low |
				(wr_ctrl ? sfr_wdata_i[`TTCF_BIT_LO_FLAG] : low_byte_overflow_flag_ff);
			if (wr_ctrl)
			begin
				low_byte_irq_enable_ff   <= sfr_wdata_i[`TTCF_BIT_LO_IRQ_EN];
				capture_mode_enable_ff   <= sfr_wdata_i[`TTCF_BIT_CAP_EN];
				split_mode_select_ff     <= sfr_wdata_i[`TTCF_BIT_SPLIT];
				run_control_ff           <= sfr_wdata_i[`TTCF_BIT_RUN];
				external_clock_select_ff <= sfr_wdata_i[`TTCF_BIT_XCLK];
			end
		end
	end

	// ==========================================================
	// Read data, one cycle behind the address; unmapped reads zero
	always @*
	begin
		nxt_rdata = `TTCF_RST_BYTE;
		case (sfr_addr_i)
			`TTCF_ADDR_CTRL:
			begin
				nxt_rdata[`TTCF_BIT_HI_FLAG]   = high_byte_overflow_flag_ff;
				nxt_rdata[`TTCF_BIT_LO_FLAG]   = low_byte_overflow_flag_ff;
				nxt_rdata[`TTCF_BIT_LO_IRQ_EN] = low_byte_irq_enable_ff;
				nxt_rdata[`TTCF_BIT_CAP_EN]    = capture_mode_enable_ff;
				nxt_rdata[`TTCF_BIT_SPLIT]     = split_mode_select_ff;
				nxt_rdata[`TTCF_BIT_RUN]       = run_control_ff;
				nxt_rdata[`TTCF_BIT_XCLK]      = external_clock_select_ff;
			end
			`TTCF_ADDR_RLD_LO: nxt_rdata = reload_low_byte_ff;
			`TTCF_ADDR_RLD_HI: nxt_rdata = reload_high_byte_ff;
			`TTCF_ADDR_CNT_LO: nxt_rdata = count_low_byte_ff;
			`TTCF_ADDR_CNT_HI: nxt_rdata = count_high_byte_ff;
			default:           nxt_rdata = `TTCF_RST_BYTE;
		endcase
	end

	// ==========================================================
	// Registered outputs. The request is a level that follows the flags,
	// so it drops only once software clears them or their enables.
	always @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			rdata_ff <= `TTCF_RST_BYTE;
			irq_ff   <= `TTCF_RST_BIT;
		end
		else
		begin
			rdata_ff <= nxt_rdata;
			irq_ff   <= timer_irq_enable_i &
				(high_byte_overflow_flag_ff | (low_byte_irq_enable_ff & low_byte_overflow_flag_ff));
		end
	end

	assign sfr_rdata_o = rdata_ff;
	assign irq_o       = irq_ff;

endmodule // ttcf_timer
`default_nettype wire

// >>> tb/ttcf_timer_props.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// Control register and request checker
module ttcf_timer_props
(
	// Clock and reset
	input wire logic       clk_i,
	input wire logic       nrst_i,
	// Register port
	input wire logic [7:0] sfr_addr_i,
	input wire logic       sfr_wr_i,
	input wire logic [7:0] sfr_wdata_i,
	input wire logic [7:0] sfr_rdata_o,
	// Interrupt
	input wire logic       timer_irq_enable_i,
	input wire logic       irq_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!nrst_i);
	// Read data shows control, no write could make it stale
	sequence s_view;
		$past(sfr_addr_i) == 8'hc8 && !$past(sfr_wr_i);
	endsequence
	// Control addressed and left alone
	sequence s_idle;
		sfr_addr_i == 8'hc8 && !sfr_wr_i;
	endsequence
	// Software write into control
	sequence s_write;
		sfr_wr_i && sfr_addr_i == 8'hc8;
	endsequence
	bit_one_zero_a: assert property (s_view |-> !sfr_rdata_o[1])
		else $error("control bit 1 read high");
	unmapped_zero_a: assert property ($past(sfr_addr_i) < 8'hc8 |-> sfr_rdata_o == 8'h00)
		else $error("unmapped read not zero");
	flags_sticky_a: assert property (s_view ##0 s_idle |=> ((sfr_rdata_o & $past(sfr_rdata_o)) & 8'hc0) == ($past(sfr_rdata_o) & 8'hc0))
		else $error("flag dropped without write");
	ctrl_hold_a: assert property (s_view ##0 s_idle |=> (sfr_rdata_o & 8'h3f) == ($past(sfr_rdata_o) & 8'h3f))
		else $error("control bits changed alone");
	ctrl_write_a: assert property (s_write ##1 s_idle |=> (sfr_rdata_o & 8'h3d) == ($past(sfr_wdata_i, 2) & 8'h3d))
		else $error("control write not kept");
	irq_off_a: assert property (!timer_irq_enable_i |=> !irq_o)
		else $error("request while disabled");
	irq_raise_a: assert property (s_view ##0 (sfr_rdata_o[7] || (sfr_rdata_o[6] && sfr_rdata_o[5])) && !sfr_wr_i
		##1 timer_irq_enable_i && !sfr_wr_i |=> irq_o)
		else $error("flag set but no request");
	reset_quiet_a: assert property (disable iff (1'b0) !nrst_i |-> sfr_rdata_o == 8'h00 && !irq_o)
		else $error("outputs active in reset");
endmodule // ttcf_timer_props

bind ttcf_timer ttcf_timer_props u_props (.clk_i(clk_i), .nrst_i(nrst_i), .sfr_addr_i(sfr_addr_i),
	.sfr_wr_i(sfr_wr_i), .sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o),
	.timer_irq_enable_i(timer_irq_enable_i), .irq_o(irq_o));
`default_nettype wire

// >>> tb/ttcf_timer_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module ttcf_timer_tb_top;
	// ==========
	// Stimulus and observed signals
	logic       clk_i = 1'b0;
	logic       nrst_i = 1'b1;
	logic [7:0] sfr_addr_i = 8'hc8;
	logic       sfr_wr_i = 1'b0;
	logic [7:0] sfr_wdata_i = 8'h00;
	logic       hsel = 1'b1;
	logic       lsel = 1'b0;
	logic       ien = 1'b0;
	logic       osc = 1'b0;
	logic [7:0] sfr_rdata_o;
	logic       irq_o;
	logic [7:0] rv;
	logic [15:0] rl;
	logic [15:0] w;
	int         failures = 0;
	int         samples_checked = 0;
	int         cycles = 0;

	ttcf_timer dut (.clk_i(clk_i), .nrst_i(nrst_i), .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i),
		.sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o), .high_byte_clock_select_i(hsel),
		.low_byte_clock_select_i(lsel), .timer_irq_enable_i(ien), .ext_osc_i(osc), .irq_o(irq_o));

	// 25 ns clock
	initial forever #12.5 clk_i = ~clk_i;

	// Hang guard, run needs under a thousand cycles
	always @(posedge clk_i)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			failures++;
			give_verdict();
		end
	end

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic check_eq(input logic [15:0] got, input logic [15:0] exp, input string what);
		samples_checked++;
		if (got !== exp)
		begin
			failures++;
			$display("BAD %0t %s got %h want %h", $time, what, got, exp);
		end
	endtask

	task automatic check_in(input logic [15:0] got, input logic [15:0] lo, input logic [15:0] hi, input string what);
		samples_checked++;
		if ((got >= lo && got <= hi) !== 1'b1)
		begin
			failures++;
			$display("BAD %0t %s got %h", $time, what, got);
		end
	endtask

	// Control reads back without the unused bit
	function automatic logic [7:0] exp_ctl(input logic [7:0] v);
		return v & 8'hfd;
	endfunction

	// ==========
	// Register port cycles, one write strobe per cycle pair
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_i);
		sfr_addr_i = a;
		sfr_wdata_i = d;
		sfr_wr_i = 1'b1;
		@(negedge clk_i);
		sfr_wr_i = 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk_i);
		sfr_addr_i = a;
		@(negedge clk_i);
		d = sfr_rdata_o;
	endtask

	// Byte pair read; only meaningful while stopped
	task automatic rd16(input logic [7:0] a, output logic [15:0] v);
		logic [7:0] l;
		logic [7:0] h;
		rd(a, l);
		rd(a + 8'h01, h);
		v = {h, l};
	endtask

	// Oscillator pin, period 10 cycles, n rising edges
	task automatic pulse_osc(input int n);
		repeat (2 * n)
		begin
			repeat (5) @(negedge clk_i);
			osc = ~osc;
		end
	endtask

	// ==========
	// Main sequence
	initial
	begin
		rv = $urandom(32'hc5800473);
		// Reset falls as a real edge, so the flops are clear before the first clock
		#1 nrst_i = 1'b0;
		rl = {8'($urandom_range(8'hef)), 8'($urandom_range(8'hef))};
		repeat (8) @(negedge clk_i);
		nrst_i = 1'b1;
		rd(8'hc8, rv);
		check_eq(rv, 8'h00, "ctl reset");
		rd(8'hc0, rv);
		check_eq(rv, 8'h00, "unmapped");
		wr(8'hc8, 8'h3e);
		rd(8'hc8, rv);
		check_eq(rv, exp_ctl(8'h3e), "ctl bits");
		wr(8'hc8, 8'h00);
		$display("test reset_regs done");
		lsel = 1'b1;
		ien = 1'b1;
		wr(8'hca, rl[7:0]);
		wr(8'hcb, rl[15:8]);
		wr(8'hcc, 8'hfd);
		wr(8'hcd, 8'hff);
		wr(8'hc8, 8'h04);
		// Wrap lands three edges after the run bit; let flag and request settle
		repeat (4) @(negedge clk_i);
		rd(8'hc8, rv);
		check_eq(rv[7], 1'b1, "word wrap flag");
		check_eq(irq_o, 1'b1, "high request");
		wr(8'hc8, 8'hc0);
		rd16(8'hcc, w);
		check_eq(w[15:8], rl[15:8], "reload high");
		check_in(w, rl, rl + 16'h0010, "reload word");
		repeat (5) @(negedge clk_i);
		rd(8'hcc, rv);
		check_eq(rv, w[7:0], "count held");
		wr(8'hc8, 8'h40);
		@(negedge clk_i);
		check_eq(irq_o, 1'b0, "low masked");
		wr(8'hc8, 8'h60);
		@(negedge clk_i);
		check_eq(irq_o, 1'b1, "low request");
		$display("test word_mode done");
		wr(8'hcd, 8'h10);
		wr(8'hcc, 8'hfe);
		wr(8'hc8, 8'h08);
		repeat (4) @(negedge clk_i);
		rd(8'hc8, rv);
		check_eq(rv, exp_ctl(8'h48), "split low flag");
		rd(8'hcd, rv);
		check_eq(rv, 8'h10, "upper gated");
		wr(8'hcd, 8'hff);
		wr(8'hc8, 8'h0c);
		rd(8'hc8, rv);
		check_eq(rv[7], 1'b1, "upper flag");
		wr(8'hc8, 8'h08);
		rd(8'hcd, rv);
		check_in(rv, rl[15:8], rl[15:8] + 8'h08, "upper reload");
		// Low byte free-runs: fe then ff, so its wrap meets the flag clear
		wr(8'hcc, 8'hfe);
		wr(8'hc8, 8'h08);
		rd(8'hc8, rv);
		check_eq(rv[6], 1'b1, "set beats clear");
		$display("test split_mode done");
		lsel = 1'b0;
		wr(8'hc8, 8'h00);
		wr(8'hcc, 8'h00);
		wr(8'hcd, 8'h00);
		wr(8'hc8, 8'h04);
		repeat (120) @(negedge clk_i);
		wr(8'hc8, 8'h00);
		rd16(8'hcc, w);
		check_in(w, 16'h0009, 16'h000b, "core by 12");
		wr(8'hcc, 8'h00);
		wr(8'hc8, 8'h05);
		pulse_osc(24);
		wr(8'hc8, 8'h01);
		rd16(8'hcc, w);
		check_in(w, 16'h0002, 16'h0003, "osc by 8");
		$display("test clock_sources done");
		lsel = 1'b1;
		wr(8'hcc, 8'h00);
		wr(8'hca, 8'h00);
		wr(8'hcb, 8'h00);
		wr(8'hc8, 8'h14);
		pulse_osc(8);
		rd(8'hc8, rv);
		check_eq(rv[7], 1'b1, "capture flag");
		wr(8'hc8, 8'h00);
		rd16(8'hca, w);
		check_in(w, 16'h0040, 16'h0060, "captured count");
		$display("test capture done");
		give_verdict();
	end
endmodule // ttcf_timer_tb_top
`default_nettype wire
